//--- logic/cmbf_top.v
// CAN message buffering, priority transmit scheduling and identifier acceptance filter
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cmbf_regs.vh"
// Register map, one byte per index:
//   0x00 receive flags: bit 0 full, bit 1 overrun, write one to clear
//   0x01 transmit flags: bits 2:0 empty, bits 6:4 abort acknowledge
//        Writing one to an empty bit hands that buffer to the scheduler
//   0x02 abort request, bits 2:0, only for buffers already handed over
//   0x03 filter control: mode in bits 1:0, hit index in bits 5:4 (read only)
//        Mode 0 single 32-bit, 1 dual 16-bit, 2 quad 8-bit, 3 closed
//   0x04-0x07 acceptance pattern, 0x08-0x0b mask (one means don't care)
//   0x10-0x1c foreground receive buffer, read only
//   0x20 + 16n, offsets 0-12 transmit buffer n, offset 13 its priority
// Limitations:
//   Filter registers are locked while transmitting or with the second stage held,
//   so the bank cannot change during a transmission or while a frame waits in the second stage.
//   Transmit buffers only accept writes while their empty flag is set.
//   Unmapped reads return zero.
module cmbf_top #(
    parameter NUM_TX = 3,
    parameter LOCAL_PRIORITY_FIELD_W = 8
) (
    input wire CLK,
    input wire RST_B,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Protocol side, receive byte stream into background buffer
    input wire RX_START,
    input wire [3:0] RX_BYTE_IDX,
    input wire [7:0] RX_BYTE,
    input wire RX_BYTE_VALID,
    input wire RX_DONE_OK,
    input wire RX_OWN,
    input wire LOOPBACK,
    input wire ARB_LOST,
    // Protocol side, transmit handshake
    input wire ARB_START,
    input wire TX_OK,
    input wire TX_ERR,
    input wire [3:0] TX_BYTE_IDX,
    output reg [7:0] TX_BYTE,
    output reg TX_REQ,
    output reg [1:0] TX_SEL,
    output reg TX_ACTIVE,
    output reg RX_IRQ,
    output reg TX_IRQ,
    output reg OVR_IRQ,
    output reg [1:0] FILT_HIT
);
    reg [7:0] rx_background_buffer [0:`CMBF_BUF_BYTES-1];
    reg [7:0] rx_foreground_buffer [0:`CMBF_BUF_BYTES-1];
    reg [7:0] tx_buf [0:NUM_TX*`CMBF_BUF_BYTES-1];
    reg [LOCAL_PRIORITY_FIELD_W-1:0] tx_buffer_priority_reg [0:NUM_TX-1];
    reg [7:0] acceptance_pattern_regs [0:3];
    reg [7:0] acceptance_mask_regs [0:3];
    reg rx_full_flag;
    reg overrun_flag;
    reg bg_full;
    reg [1:0] bg_hit;
    reg [1:0] filter_mode;
    reg [1:0] filter_hit_indicator;
    reg [NUM_TX-1:0] tx_empty_flag;
    reg [NUM_TX-1:0] abort_request_bit;
    reg [NUM_TX-1:0] abort_ack_bit;
    reg [1:0] cur_sel;
    reg sending;
    reg own_frame;
    integer i;
    // Filter evaluation on the identifier bytes held in the background buffer
    reg [3:0] hits;
    reg accept;
    reg [1:0] hit_idx;
    reg [7:0] diff [0:3];
    always @*
    begin
        for (i = 0; i < 4; i = i + 1)
            diff[i] = (rx_background_buffer[i] ^ acceptance_pattern_regs[i]) & ~acceptance_mask_regs[i];
        hits = 4'h0;
        case (filter_mode)
            `CMBF_MODE_SINGLE: hits[0] = ~|{diff[0], diff[1], diff[2], diff[3]};
            `CMBF_MODE_DUAL:
            begin
                // Each filter covers two identifier bytes against its own register pair
                hits[0] = ~|(((rx_background_buffer[0] ^ acceptance_pattern_regs[0]) & ~acceptance_mask_regs[0])
                    | ((rx_background_buffer[1] ^ acceptance_pattern_regs[1]) & ~acceptance_mask_regs[1]));
                hits[1] = ~|(((rx_background_buffer[0] ^ acceptance_pattern_regs[2]) & ~acceptance_mask_regs[2])
                    | ((rx_background_buffer[1] ^ acceptance_pattern_regs[3]) & ~acceptance_mask_regs[3]));
            end
            `CMBF_MODE_QUAD:
            begin
                for (i = 0; i < 4; i = i + 1)
                    hits[i] = ~|((rx_background_buffer[0] ^ acceptance_pattern_regs[i])
                        & ~acceptance_mask_regs[i]);
            end
            default: hits = 4'h0;
        endcase
        accept = |hits;
        // Lowest numbered filter is reported when several match
        if (hits[0])
            hit_idx = 2'h0;
        else if (hits[1])
            hit_idx = 2'h1;
        else if (hits[2])
            hit_idx = 2'h2;
        else
            hit_idx = 2'h3;
    end

    // Scheduler: pending buffer with smallest priority value
    reg [1:0] best;
    reg best_valid;
    reg [LOCAL_PRIORITY_FIELD_W-1:0] best_local_priority_field;
    always @*
    begin
        best = 2'h0;
        best_valid = 1'b0;
        best_local_priority_field = {LOCAL_PRIORITY_FIELD_W{1'b1}};
        for (i = 0; i < NUM_TX; i = i + 1)
            if (!tx_empty_flag[i] && (!best_valid || tx_buffer_priority_reg[i] < best_local_priority_field))
            begin
                best = i[1:0];
                best_valid = 1'b1;
                best_local_priority_field = tx_buffer_priority_reg[i];
            end
    end

    wire frame_ok = RX_DONE_OK && (!own_frame || LOOPBACK);
    wire is_ctrl_wr = WR && ADDR < `CMBF_RX_FOREGROUND_BUFFER_BASE;
    wire [7:0] tx_rel = ADDR - `CMBF_TXBUF_BASE;
    wire tx_hit = WR && ADDR >= `CMBF_TXBUF_BASE && ADDR < `CMBF_TXBUF_BASE + NUM_TX * `CMBF_TXBUF_STRIDE;
    wire [1:0] tx_wbuf = tx_rel[5:4];
    wire [3:0] tx_woff = tx_rel[3:0];
    // Config registers locked while transmitting or while a frame waits in the second stage
    wire cfg_ok = !sending && !bg_full;

    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rx_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            bg_full <= 1'b0;
            bg_hit <= 2'h0;
            filter_mode <= `CMBF_MODE_SINGLE;
            filter_hit_indicator <= 2'h0;
            tx_empty_flag <= `CMBF_TXE_RESET;
            abort_request_bit <= 3'h0;
            abort_ack_bit <= 3'h0;
            cur_sel <= 2'h0;
            sending <= 1'b0;
            own_frame <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
            begin
                acceptance_pattern_regs[i] <= 8'h00;
                acceptance_mask_regs[i] <= 8'h00;
            end
            for (i = 0; i < NUM_TX; i = i + 1)
                tx_buffer_priority_reg[i] <= {LOCAL_PRIORITY_FIELD_W{1'b0}};
        end
        else
        begin
            // Receive: bytes 0-12 land in the background buffer unless the second stage is held full
            if (RX_START)
                own_frame <= sending && !ARB_LOST;
            if (ARB_LOST)
            begin
                own_frame <= 1'b0;
                sending <= 1'b0;
            end
            if (RX_BYTE_VALID && RX_BYTE_IDX < `CMBF_BUF_BYTES && !bg_full)
                rx_background_buffer[RX_BYTE_IDX] <= RX_BYTE;
            // Software clears, set wins over clear
            if (WR && ADDR == `CMBF_RX_FLAG_REG)
            begin
                if (WDATA[`CMBF_RXF_BIT])
                    rx_full_flag <= 1'b0;
                if (WDATA[`CMBF_OVR_BIT])
                    overrun_flag <= 1'b0;
            end
            if (frame_ok && accept)
            begin
                if (!rx_full_flag)
                begin
                    for (i = 0; i < `CMBF_BUF_BYTES; i = i + 1)
                        rx_foreground_buffer[i] <= rx_background_buffer[i];
                    rx_full_flag <= 1'b1;
                    filter_hit_indicator <= hit_idx;
                end
                else if (!bg_full)
                begin
                    bg_full <= 1'b1;
                    bg_hit <= hit_idx;
                end
                else
                    overrun_flag <= 1'b1;
            end
            else if (bg_full && !rx_full_flag)
            begin
                // Second stage drains forward once the CPU frees the foreground
                for (i = 0; i < `CMBF_BUF_BYTES; i = i + 1)
                    rx_foreground_buffer[i] <= rx_background_buffer[i];
                rx_full_flag <= 1'b1;
                filter_hit_indicator <= bg_hit;
                bg_full <= 1'b0;
            end
            // Configuration writes
            if (WR && ADDR == `CMBF_FILT_CTRL_REG && cfg_ok)
                filter_mode <= WDATA[`CMBF_MODE_LO +: 2];
            for (i = 0; i < 4; i = i + 1)
            begin
                if (WR && cfg_ok && ADDR == `CMBF_PATTERN_BASE + i[7:0])
                    acceptance_pattern_regs[i] <= WDATA;
                if (WR && cfg_ok && ADDR == `CMBF_MASK_BASE + i[7:0])
                    acceptance_mask_regs[i] <= WDATA;
            end
            // Transmit buffer load
            if (tx_hit && tx_empty_flag[tx_wbuf])
            begin
                if (tx_woff < `CMBF_BUF_BYTES)
                    tx_buf[tx_wbuf * `CMBF_BUF_BYTES + tx_woff] <= WDATA;
                else if (tx_woff == `CMBF_LOCAL_PRIORITY_FIELD_OFFSET)
                    tx_buffer_priority_reg[tx_wbuf] <= WDATA[LOCAL_PRIORITY_FIELD_W-1:0];
            end
            // Writing one to an empty flag marks the buffer ready
            if (WR && ADDR == `CMBF_TX_FLAG_REG)
                for (i = 0; i < NUM_TX; i = i + 1)
                    if (WDATA[i] && tx_empty_flag[i])
                    begin
                        tx_empty_flag[i] <= 1'b0;
                        abort_ack_bit[i] <= 1'b0;
                    end
            if (WR && ADDR == `CMBF_TX_CTRL_REG)
                abort_request_bit <= WDATA[2:0] & ~tx_empty_flag;
            // Abort only buffers not in flight
            for (i = 0; i < NUM_TX; i = i + 1)
                if (abort_request_bit[i] && !tx_empty_flag[i] && !(sending && cur_sel == i[1:0]))
                begin
                    tx_empty_flag[i] <= 1'b1;
                    abort_ack_bit[i] <= 1'b1;
                    abort_request_bit[i] <= 1'b0;
                end
            // Arbitration: choose anew every time, including retries
            if (ARB_START && best_valid)
            begin
                cur_sel <= best;
                sending <= 1'b1;
            end
            if (TX_OK && sending)
            begin
                tx_empty_flag[cur_sel] <= 1'b1;
                abort_ack_bit[cur_sel] <= 1'b0;
                abort_request_bit[cur_sel] <= 1'b0;
                sending <= 1'b0;
            end
            if (TX_ERR)
                sending <= 1'b0;
        end
    end

    // Registered outputs
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            RDATA <= 8'h00;
            TX_BYTE <= 8'h00;
            TX_REQ <= 1'b0;
            TX_SEL <= 2'h0;
            TX_ACTIVE <= 1'b0;
            RX_IRQ <= 1'b0;
            TX_IRQ <= 1'b0;
            OVR_IRQ <= 1'b0;
            FILT_HIT <= 2'h0;
        end
        else
        begin
            RX_IRQ <= rx_full_flag;
            TX_IRQ <= |tx_empty_flag;
            OVR_IRQ <= overrun_flag;
            FILT_HIT <= filter_hit_indicator;
            TX_REQ <= best_valid;
            TX_SEL <= cur_sel;
            TX_ACTIVE <= sending;
            TX_BYTE <= (TX_BYTE_IDX < `CMBF_BUF_BYTES) ? tx_buf[cur_sel * `CMBF_BUF_BYTES + TX_BYTE_IDX] : 8'h00;
            RDATA <= 8'h00;
            if (RD)
            begin
                if (ADDR == `CMBF_RX_FLAG_REG)
                    RDATA <= {6'h00, overrun_flag, rx_full_flag};
                else if (ADDR == `CMBF_TX_FLAG_REG)
                    RDATA <= {1'b0, abort_ack_bit, 1'b0, tx_empty_flag};
                else if (ADDR == `CMBF_TX_CTRL_REG)
                    RDATA <= {5'h00, abort_request_bit};
                else if (ADDR == `CMBF_FILT_CTRL_REG)
                    RDATA <= {2'h0, filter_hit_indicator, 2'h0, filter_mode};
                else if (ADDR >= `CMBF_PATTERN_BASE && ADDR < `CMBF_PATTERN_BASE + 8'h04)
                    RDATA <= acceptance_pattern_regs[ADDR[1:0]];
                else if (ADDR >= `CMBF_MASK_BASE && ADDR < `CMBF_MASK_BASE + 8'h04)
                    RDATA <= acceptance_mask_regs[ADDR[1:0]];
                else if (ADDR >= `CMBF_RX_FOREGROUND_BUFFER_BASE && ADDR < `CMBF_RX_FOREGROUND_BUFFER_BASE + `CMBF_BUF_BYTES)
                    RDATA <= rx_foreground_buffer[ADDR[3:0]];
                else if (tx_rel < NUM_TX * `CMBF_TXBUF_STRIDE && ADDR >= `CMBF_TXBUF_BASE)
                begin
                    if (tx_rel[3:0] < `CMBF_BUF_BYTES)
                        RDATA <= tx_buf[tx_rel[5:4] * `CMBF_BUF_BYTES + tx_rel[3:0]];
                    else if (tx_rel[3:0] == `CMBF_LOCAL_PRIORITY_FIELD_OFFSET)
                        RDATA <= tx_buffer_priority_reg[tx_rel[5:4]];
                end
            end
        end
    end
endmodule // cmbf_top
`default_nettype wire

//--- common/cmbf_regs.vh
// Register offsets, field positions and reset values of the CAN message buffer and filter block
`ifndef CMBF_REGS_VH
`define CMBF_REGS_VH
// Register offsets (word index)
`define CMBF_RX_FLAG_REG 8'h00
`define CMBF_TX_FLAG_REG 8'h01
`define CMBF_TX_CTRL_REG 8'h02
`define CMBF_FILT_CTRL_REG 8'h03
`define CMBF_PATTERN_BASE 8'h04
`define CMBF_MASK_BASE 8'h08
`define CMBF_RX_FOREGROUND_BUFFER_BASE 8'h10
`define CMBF_TXBUF_BASE 8'h20
`define CMBF_TXBUF_STRIDE 8'h10
`define CMBF_LOCAL_PRIORITY_FIELD_OFFSET 8'h0d
// Receiver flag register fields
`define CMBF_RXF_BIT 0
`define CMBF_OVR_BIT 1
// Filter control fields: mode in [1:0], hit in [5:4]
`define CMBF_MODE_LO 0
`define CMBF_HIT_LO 4
// Filter mode encodings
`define CMBF_MODE_SINGLE 2'h0
`define CMBF_MODE_DUAL 2'h1
`define CMBF_MODE_QUAD 2'h2
`define CMBF_MODE_CLOSED 2'h3
// Transmit control: abort request in [2:0]; flag reg: empty in [2:0], ack in [6:4]
`define CMBF_ABORT_ACK_BIT_LO 4
`define CMBF_TXE_RESET 3'h7
`define CMBF_BUF_BYTES 13
`endif

//--- tb/cmbf_checker.sv
// Assertion checker for the CAN message buffer and filter block
`timescale 1ns/1ps
`default_nettype none
module cmbf_checker (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic RX_DONE_OK,
    input wire logic ARB_START,
    input wire logic ARB_LOST,
    input wire logic TX_OK,
    input wire logic TX_ERR,
    input wire logic [1:0] TX_SEL,
    input wire logic TX_ACTIVE,
    input wire logic RX_IRQ,
    input wire logic TX_IRQ,
    input wire logic OVR_IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    // A copy forward follows either a completed frame or a clear of the full flag
    a_rx_cause: assert property ($rose(RX_IRQ) |-> $past(RX_DONE_OK, 2) || $past(WR, 2) || $past(WR, 3))
        else $error("receive full without a frame or a clear");
    a_rx_hold: assert property (RX_IRQ && !WR && !$past(WR) |=> RX_IRQ)
        else $error("receive full dropped without a clear");
    a_ovr_cause: assert property ($rose(OVR_IRQ) |-> $past(RX_DONE_OK, 2) && $past(RX_IRQ))
        else $error("overrun without a frame into full buffers");
    a_tx_done_irq: assert property (TX_ACTIVE && TX_OK |-> ##[1:2] TX_IRQ)
        else $error("no transmit interrupt after a sent frame");
    a_tx_start: assert property ($rose(TX_ACTIVE) |-> $past(ARB_START) || $past(ARB_START, 2))
        else $error("transmission began without arbitration");
    // The end pulse clears the in-flight state at its edge; the registered output follows one cycle later
    a_tx_end: assert property (TX_ACTIVE && (TX_OK || TX_ERR || ARB_LOST) |-> ##2 !TX_ACTIVE)
        else $error("transmission still active after its end");
    a_sel_hold: assert property (TX_ACTIVE && $past(TX_ACTIVE) |-> $stable(TX_SEL))
        else $error("selected buffer changed in flight");
endmodule // cmbf_checker
bind cmbf_top cmbf_checker cmbf_checker_i (.CLK, .RST_B, .WR, .RD, .RDATA, .RX_DONE_OK, .ARB_START, .ARB_LOST,
    .TX_OK, .TX_ERR, .TX_SEL, .TX_ACTIVE, .RX_IRQ, .TX_IRQ, .OVR_IRQ);
`default_nettype wire

//--- tb/cmbf_can_model.sv
// Behavioural model of the CAN protocol engine and bus feeding the buffer block
`timescale 1ns/1ps
`default_nettype none
module cmbf_can_model (
    input wire logic CLK,
    input wire logic TX_ACTIVE,
    output logic RX_START,
    output logic [3:0] RX_BYTE_IDX,
    output logic [7:0] RX_BYTE,
    output logic RX_BYTE_VALID,
    output logic RX_DONE_OK,
    output logic RX_OWN,
    output logic ARB_LOST,
    output logic ARB_START,
    output logic TX_OK,
    output logic TX_ERR,
    output logic [3:0] TX_BYTE_IDX
);
    initial
    begin
        {RX_START, RX_BYTE_IDX, RX_BYTE, RX_BYTE_VALID, RX_DONE_OK, RX_OWN} = '0;
        {ARB_LOST, ARB_START, TX_OK, TX_ERR, TX_BYTE_IDX} = '0;
    end
    // Every frame is streamed whole, whatever the filter will decide
    task automatic frame(input logic [31:0] id, input logic [7:0] tag);
        int k;
        @(posedge CLK) RX_START <= 1'b1;
        for (k = 0; k < 13; k++)
        begin
            @(posedge CLK) RX_START <= 1'b0;
            RX_BYTE_VALID <= 1'b1;
            RX_BYTE_IDX <= k[3:0];
            RX_BYTE <= (k < 4) ? id[31 - 8 * k -: 8] : tag;
        end
        @(posedge CLK) RX_BYTE_VALID <= 1'b0;
        RX_DONE_OK <= 1'b1;
        // Released lane flips so a stale byte is never taken for a fresh one
        RX_BYTE <= ~RX_BYTE;
        @(posedge CLK) RX_DONE_OK <= 1'b0;
    endtask
    task automatic arb();
        int k;
        @(posedge CLK) ARB_START <= 1'b1;
        @(posedge CLK) ARB_START <= 1'b0;
        for (k = 0; k < 8 && TX_ACTIVE !== 1'b1; k++)
            @(posedge CLK);
    endtask
    // One-hot end of an attempt: sent, error then retry, or arbitration lost
    task automatic finish(input logic [2:0] ev);
        @(posedge CLK) {ARB_LOST, TX_ERR, TX_OK} <= ev;
        @(posedge CLK) {ARB_LOST, TX_ERR, TX_OK} <= 3'h0;
    endtask
endmodule // cmbf_can_model
`default_nettype wire

//--- tb/cmbf_top_test.sv
// Self-checking testbench of the CAN message buffer and filter block
`timescale 1ns/1ps
`default_nettype none
module cmbf_top_test;
    localparam logic [31:0] ID = 32'h5a3c1122;
    logic CLK, RST_B, WR, RD, LOOPBACK;
    logic [7:0] ADDR, WDATA;
    wire [7:0] RDATA, TX_BYTE, RX_BYTE;
    wire [3:0] RX_BYTE_IDX, TX_BYTE_IDX;
    wire [1:0] TX_SEL, FILT_HIT;
    wire RX_START, RX_BYTE_VALID, RX_DONE_OK, RX_OWN, ARB_LOST, ARB_START, TX_OK, TX_ERR;
    wire TX_REQ, TX_ACTIVE, RX_IRQ, TX_IRQ, OVR_IRQ;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int m, k;
    logic [31:0] pat [4] = '{32'h5a3c11ff, 32'h00005a3c, 32'h00015a5a, ID};
    logic [31:0] msk [4] = '{32'h000000ff, 32'h0, 32'h0, 32'h0};
    cmbf_top cmbf_top_i (.CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_START, .RX_BYTE_IDX, .RX_BYTE,
        .RX_BYTE_VALID, .RX_DONE_OK, .RX_OWN, .LOOPBACK, .ARB_LOST, .ARB_START, .TX_OK, .TX_ERR, .TX_BYTE_IDX,
        .TX_BYTE, .TX_REQ, .TX_SEL, .TX_ACTIVE, .RX_IRQ, .TX_IRQ, .OVR_IRQ, .FILT_HIT);
    cmbf_can_model cmbf_can_model_i (.CLK, .TX_ACTIVE, .RX_START, .RX_BYTE_IDX, .RX_BYTE, .RX_BYTE_VALID,
        .RX_DONE_OK, .RX_OWN, .ARB_LOST, .ARB_START, .TX_OK, .TX_ERR, .TX_BYTE_IDX);
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK) ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK) WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK) ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK) RD <= 1'b0;
        #1;
        chk(RDATA, exp);
    endtask
    task automatic go(input logic [1:0] sel);
        cmbf_can_model_i.arb();
        repeat (2) @(posedge CLK);
        #1;
        chk({6'h0, TX_SEL}, {6'h0, sel});
        chk({7'h0, TX_ACTIVE}, 8'h01);
        chk(TX_BYTE, 8'ha0 + {6'h0, sel});
    endtask
    initial
    begin
        {RST_B, WR, RD, LOOPBACK, ADDR, WDATA} = '0;
        repeat (5) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (2) @(posedge CLK);
        rd(8'h01, 8'h07);
        rd(8'h0f, 8'h00);
        chk({7'h0, TX_IRQ}, 8'h01);
        chk({7'h0, TX_REQ}, 8'h00);
        // Modes single, dual, quad, closed; hit index equals the mode where accepted
        for (m = 0; m < 4; m++)
        begin
            wr(8'h03, m[7:0]);
            for (k = 0; k < 4; k++)
            begin
                wr(8'h04 + k[7:0], pat[m][31 - 8 * k -: 8]);
                wr(8'h08 + k[7:0], msk[m][31 - 8 * k -: 8]);
            end
            cmbf_can_model_i.frame(ID, 8'h01);
            repeat (3) @(posedge CLK);
            rd(8'h00, {7'h0, m != 3});
            if (m != 3)
            begin
                rd(8'h03, {2'h0, m[1:0], 2'h0, m[1:0]});
                chk({6'h0, FILT_HIT}, {6'h0, m[1:0]});
                chk({7'h0, RX_IRQ}, 8'h01);
                rd(8'h10, 8'h5a);
                rd(8'h1c, 8'h01);
            end
            wr(8'h00, 8'h01);
        end
        wr(8'h03, 8'h00);
        for (k = 1; k < 4; k++)
            cmbf_can_model_i.frame(ID, k[7:0]);
        repeat (3) @(posedge CLK);
        rd(8'h00, 8'h03);
        chk({7'h0, OVR_IRQ}, 8'h01);
        rd(8'h14, 8'h01);
        wr(8'h00, 8'h03);
        repeat (3) @(posedge CLK);
        rd(8'h00, 8'h01);
        rd(8'h14, 8'h02);
        wr(8'h00, 8'h01);
        for (k = 0; k < 3; k++)
        begin
            wr(8'h20 + 8'h10 * k[7:0], 8'ha0 + k[7:0]);
            wr(8'h2d + 8'h10 * k[7:0], (k == 0) ? 8'h30 : 8'h10 * k[7:0]);
        end
        wr(8'h01, 8'h07);
        repeat (2) @(posedge CLK);
        chk({7'h0, TX_IRQ}, 8'h00);
        chk({7'h0, TX_REQ}, 8'h01);
        wr(8'h02, 8'h02);
        repeat (2) @(posedge CLK);
        rd(8'h01, 8'h22);
        go(2'h2);
        cmbf_can_model_i.finish(3'b010);
        go(2'h2);
        cmbf_can_model_i.finish(3'b001);
        repeat (3) @(posedge CLK);
        rd(8'h01, 8'h26);
        go(2'h0);
        cmbf_can_model_i.frame(ID, 8'h09);
        cmbf_can_model_i.finish(3'b001);
        repeat (3) @(posedge CLK);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h27);
        wr(8'h01, 8'h01);
        go(2'h0);
        cmbf_can_model_i.finish(3'b100);
        cmbf_can_model_i.frame(ID, 8'h07);
        repeat (3) @(posedge CLK);
        rd(8'h00, 8'h01);
        rd(8'h1c, 8'h07);
        summarize();
    end
endmodule // cmbf_top_test
`default_nettype wire
